/* File: design/sea_pkg.sv */
// Package with register indices, field positions and reset values for the status aggregator
package sea_pkg;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [3:0] SEA_IDX_OPER_EVENT = 4'h0;
  localparam logic [3:0] SEA_IDX_OPER_COND  = 4'h1;
  localparam logic [3:0] SEA_IDX_OPER_ENAB  = 4'h2;
  localparam logic [3:0] SEA_IDX_OPER_FALL  = 4'h3;
  localparam logic [3:0] SEA_IDX_OPER_RISE  = 4'h4;
  localparam logic [3:0] SEA_IDX_QUES_EVENT = 4'h5;
  localparam logic [3:0] SEA_IDX_QUES_COND  = 4'h6;
  localparam logic [3:0] SEA_IDX_QUES_ENAB  = 4'h7;
  localparam logic [3:0] SEA_IDX_QUES_FALL  = 4'h8;
  localparam logic [3:0] SEA_IDX_QUES_RISE  = 4'h9;

  // ----------------------------------------
  // Widths, fields, reset values
  // ----------------------------------------
  localparam int          SEA_REG_W       = 16;
  localparam logic [15:0] SEA_VALID_MASK  = 16'h7FFF;
  localparam logic [15:0] SEA_RST_VAL     = 16'h0000;
  localparam int          SEA_STB_OPER_POS = 7;
  localparam int          SEA_STB_QUES_POS = 3;

  // ----------------------------------------
  // Command carrier
  // ----------------------------------------
  typedef struct packed {
    logic        rdEn;
    logic        wrEn;
    logic [3:0]  idx;
    logic [15:0] wrData;
  } sea_cmd_t;

  typedef enum logic [1:0] {
    SEA_ST_IDLE  = 2'b00,
    SEA_ST_RUN   = 2'b01
  } sea_state_t;

endpackage

/* File: design/status_event_aggregator.sv */
// Status event aggregator: condition, transition filter, event, enable and summary logic
//
// What this block does
// - Every register reads as 16 bits with the top bit always zero, so values lie in 0..32767.
// - An operation event bit sets on a detected operation condition edge that its filter allows.
// - A questionable event bit sets on a detected questionable condition edge its filter allows.
// - Reading an event register returns its contents and clears all its bits.
// - An event in the same cycle as the clearing read is kept after the clear.
// - Reading the operation condition register does not change it.
// - Reading the questionable condition register does not change it.
// - Condition registers follow the synchronised conditions; a bit changes only when the second and third stages agree.
// - The operation enable mask is read/write and gates event bits toward the summary.
// - Status byte bit 7 is set while any operation event bit and its enable bit are both set.
// - Status byte bit 3 is set while any questionable event bit and its enable bit are both set.
// - An operation fall filter bit lets a one-to-zero condition change set the event bit.
// - An operation rise filter bit lets a zero-to-one condition change set the event bit.
// - A questionable fall filter bit lets a one-to-zero condition change set the event bit.
// - The preset command clears the enable, filter and event registers, forcing both enable masks to zero.
// - A questionable rise filter bit lets a zero-to-one condition change set the event bit.
`timescale 1ns/100ps

module status_event_aggregator
  import sea_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [15:0] operCondIn,
  input  wire logic [15:0] quesCondIn,
  input  wire logic        cmdRdEn,
  input  wire logic        cmdWrEn,
  input  wire logic [3:0]  cmdIdx,
  input  wire logic [15:0] cmdWrData,
  input  wire logic        statusPreset,
  output logic      [15:0] rdData,
  output logic             rdValid,
  output logic             operSummary,
  output logic             quesSummary,
  output logic      [7:0]  statusByteBits
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] seaEdges(input logic [15:0] cur,
                                           input logic [15:0] prev,
                                           input logic [15:0] rise,
                                           input logic [15:0] fall);
    seaEdges = ((cur & ~prev & rise) | (~cur & prev & fall)) & SEA_VALID_MASK;
  endfunction

  sea_cmd_t cmd;
  assign cmd = '{rdEn: cmdRdEn, wrEn: cmdWrEn, idx: cmdIdx, wrData: cmdWrData};

  // ----------------------------------------
  // Condition inputs: three-stage synchronisers
  // ----------------------------------------
  logic [15:0] operSync1_ff, operSync2_ff, operSync3_ff;
  logic [15:0] quesSync1_ff, quesSync2_ff, quesSync3_ff;
  logic [15:0] operCond_ff, quesCond_ff;
  logic [15:0] operPrev_ff, quesPrev_ff;
  logic [15:0] nxt_operCond, nxt_quesCond;

  // Bit updates only where the second and third stages agree
  assign nxt_operCond = ((operSync2_ff & operSync3_ff) |
                         (operCond_ff & (operSync2_ff | operSync3_ff))) & SEA_VALID_MASK;
  assign nxt_quesCond = ((quesSync2_ff & quesSync3_ff) |
                         (quesCond_ff & (quesSync2_ff | quesSync3_ff))) & SEA_VALID_MASK;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      operSync1_ff <= SEA_RST_VAL;
      operSync2_ff <= SEA_RST_VAL;
      operSync3_ff <= SEA_RST_VAL;
      quesSync1_ff <= SEA_RST_VAL;
      quesSync2_ff <= SEA_RST_VAL;
      quesSync3_ff <= SEA_RST_VAL;
    end
    else
    begin
      operSync1_ff <= operCondIn;
      operSync2_ff <= operSync1_ff;
      operSync3_ff <= operSync2_ff;
      quesSync1_ff <= quesCondIn;
      quesSync2_ff <= quesSync1_ff;
      quesSync3_ff <= quesSync2_ff;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      operCond_ff <= SEA_RST_VAL;
      quesCond_ff <= SEA_RST_VAL;
      operPrev_ff <= SEA_RST_VAL;
      quesPrev_ff <= SEA_RST_VAL;
    end
    else
    begin
      operCond_ff <= nxt_operCond;
      quesCond_ff <= nxt_quesCond;
      operPrev_ff <= operCond_ff;
      quesPrev_ff <= quesCond_ff;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire wrOperEnab = cmd.wrEn && (cmd.idx == SEA_IDX_OPER_ENAB);
  wire wrOperFall = cmd.wrEn && (cmd.idx == SEA_IDX_OPER_FALL);
  wire wrOperRise = cmd.wrEn && (cmd.idx == SEA_IDX_OPER_RISE);
  wire wrQuesEnab = cmd.wrEn && (cmd.idx == SEA_IDX_QUES_ENAB);
  wire wrQuesFall = cmd.wrEn && (cmd.idx == SEA_IDX_QUES_FALL);
  wire wrQuesRise = cmd.wrEn && (cmd.idx == SEA_IDX_QUES_RISE);
  wire rdOperEvt  = cmd.rdEn && (cmd.idx == SEA_IDX_OPER_EVENT);
  wire rdQuesEvt  = cmd.rdEn && (cmd.idx == SEA_IDX_QUES_EVENT);
  wire [15:0] wrMasked = cmd.wrData & SEA_VALID_MASK;

  // ----------------------------------------
  // Filter and enable registers
  // ----------------------------------------
  logic [15:0] operEnab_ff, operFall_ff, operRise_ff;
  logic [15:0] quesEnab_ff, quesFall_ff, quesRise_ff;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      operEnab_ff <= SEA_RST_VAL;
      operFall_ff <= SEA_RST_VAL;
      operRise_ff <= SEA_RST_VAL;
      quesEnab_ff <= SEA_RST_VAL;
      quesFall_ff <= SEA_RST_VAL;
      quesRise_ff <= SEA_RST_VAL;
    end
    else if (statusPreset)
    begin
      operEnab_ff <= SEA_RST_VAL;
      operFall_ff <= SEA_RST_VAL;
      operRise_ff <= SEA_RST_VAL;
      quesEnab_ff <= SEA_RST_VAL;
      quesFall_ff <= SEA_RST_VAL;
      quesRise_ff <= SEA_RST_VAL;
    end
    else
    begin
      if (wrOperEnab) operEnab_ff <= wrMasked;
      if (wrOperFall) operFall_ff <= wrMasked;
      if (wrOperRise) operRise_ff <= wrMasked;
      if (wrQuesEnab) quesEnab_ff <= wrMasked;
      if (wrQuesFall) quesFall_ff <= wrMasked;
      if (wrQuesRise) quesRise_ff <= wrMasked;
    end
  end

  // ----------------------------------------
  // Event latches
  // ----------------------------------------
  logic [15:0] operEvt_ff, quesEvt_ff;
  logic [15:0] operEdge, quesEdge;
  logic [15:0] nxt_operEvt, nxt_quesEvt;

  assign operEdge = seaEdges(operCond_ff, operPrev_ff, operRise_ff, operFall_ff);
  assign quesEdge = seaEdges(quesCond_ff, quesPrev_ff, quesRise_ff, quesFall_ff);

  // Set wins over the read clear
  assign nxt_operEvt = (rdOperEvt ? SEA_RST_VAL : operEvt_ff) | operEdge;
  assign nxt_quesEvt = (rdQuesEvt ? SEA_RST_VAL : quesEvt_ff) | quesEdge;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      operEvt_ff <= SEA_RST_VAL;
      quesEvt_ff <= SEA_RST_VAL;
    end
    else if (statusPreset)
    begin
      operEvt_ff <= SEA_RST_VAL;
      quesEvt_ff <= SEA_RST_VAL;
    end
    else
    begin
      operEvt_ff <= nxt_operEvt;
      quesEvt_ff <= nxt_quesEvt;
    end
  end

  // ----------------------------------------
  // Summary bits
  // ----------------------------------------
  assign operSummary = |(operEvt_ff & operEnab_ff);
  assign quesSummary = |(quesEvt_ff & quesEnab_ff);

  always_comb
  begin
    statusByteBits = 8'h00;
    statusByteBits[SEA_STB_OPER_POS] = operSummary;
    statusByteBits[SEA_STB_QUES_POS] = quesSummary;
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [15:0] rdMux;
  logic [15:0] rdData_ff;
  logic        rdValid_ff;

  always_comb
  begin
    case (cmd.idx)
      SEA_IDX_OPER_EVENT: rdMux = operEvt_ff;
      SEA_IDX_OPER_COND:  rdMux = operCond_ff;
      SEA_IDX_OPER_ENAB:  rdMux = operEnab_ff;
      SEA_IDX_OPER_FALL:  rdMux = operFall_ff;
      SEA_IDX_OPER_RISE:  rdMux = operRise_ff;
      SEA_IDX_QUES_EVENT: rdMux = quesEvt_ff;
      SEA_IDX_QUES_COND:  rdMux = quesCond_ff;
      SEA_IDX_QUES_ENAB:  rdMux = quesEnab_ff;
      SEA_IDX_QUES_FALL:  rdMux = quesFall_ff;
      SEA_IDX_QUES_RISE:  rdMux = quesRise_ff;
      default:            rdMux = SEA_RST_VAL;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdData_ff  <= SEA_RST_VAL;
      rdValid_ff <= 1'b0;
    end
    else
    begin
      rdValid_ff <= cmd.rdEn;
      if (cmd.rdEn)
        rdData_ff <= rdMux & SEA_VALID_MASK;
    end
  end

  assign rdData  = rdData_ff;
  assign rdValid = rdValid_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cbSea @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_TOP_BIT_ZERO: assert property (rdValid |-> !rdData[15])
    else $error("read data top bit set");
  AST_OPER_EDGE_SETS: assert property ((!statusPreset && |operEdge) |=>
    ((operEvt_ff & $past(operEdge)) == $past(operEdge)))
    else $error("operation edge not latched");
  AST_QUES_EDGE_SETS: assert property ((!statusPreset && |quesEdge) |=>
    ((quesEvt_ff & $past(quesEdge)) == $past(quesEdge)))
    else $error("questionable edge not latched");
  AST_READ_CLEARS: assert property ((rdOperEvt && !statusPreset) |=>
    (operEvt_ff == $past(operEdge)))
    else $error("operation event not cleared by read");
  AST_READ_RETURNS: assert property (rdOperEvt |=> (rdData == $past(operEvt_ff)))
    else $error("event read returned wrong value");
  AST_NO_LOSS: assert property ((rdQuesEvt && !statusPreset && |quesEdge) |=>
    (quesEvt_ff != 16'h0000))
    else $error("event lost on clearing read");
  AST_COND_READ_KEEP: assert property ((cmd.rdEn && cmd.idx == SEA_IDX_OPER_COND) &&
    (operSync2_ff == operCond_ff) && (operSync3_ff == operCond_ff) |=> $stable(operCond_ff))
    else $error("operation condition changed by read");
  AST_QCOND_READ_KEEP: assert property ((cmd.rdEn && cmd.idx == SEA_IDX_QUES_COND) &&
    (quesSync2_ff == quesCond_ff) && (quesSync3_ff == quesCond_ff) |=> $stable(quesCond_ff))
    else $error("questionable condition changed by read");
  AST_COND_TRACK: assert property ((operSync2_ff == operSync3_ff) |=>
    (operCond_ff == ($past(operSync3_ff) & SEA_VALID_MASK)))
    else $error("condition does not track input");
  AST_OPER_SUMMARY: assert property (statusByteBits[7] == |(operEvt_ff & operEnab_ff))
    else $error("operation summary wrong");
  AST_QUES_SUMMARY: assert property (statusByteBits[3] == |(quesEvt_ff & quesEnab_ff))
    else $error("questionable summary wrong");
  AST_PRESET_ENAB: assert property (statusPreset |=> (operEnab_ff == 16'h0000 &&
    quesEnab_ff == 16'h0000))
    else $error("preset did not clear enables");
  AST_RISE_DETECT: assert property ((operCond_ff[0] && !operPrev_ff[0] && operRise_ff[0])
    |-> operEdge[0])
    else $error("rise not detected");
  AST_FALL_DETECT: assert property (
    (!operCond_ff[1] && operPrev_ff[1] && operFall_ff[1]) |-> operEdge[1])
    else $error("operation fall not detected");
  AST_QUES_RISE_DETECT: assert property (
    (quesCond_ff[0] && !quesPrev_ff[0] && quesRise_ff[0]) |-> quesEdge[0])
    else $error("questionable rise not detected");

  COV_OPER_EVENT: cover property (|operEdge ##1 operSummary);
  COV_QUES_EVENT: cover property (|quesEdge ##1 quesSummary);
  COV_READ_CLASH: cover property (rdOperEvt && |operEdge);
  COV_PRESET:     cover property (statusPreset);
  COV_COND_READ:  cover property (cmd.rdEn && cmd.idx == SEA_IDX_QUES_COND);

endmodule

/* File: test/status_event_aggregator_tb_top.sv */
// Self-checking testbench for the status event aggregator
`timescale 1ns/100ps

module status_event_aggregator_tb_top
  import sea_pkg::*;
;
  // ----------------------------------------
  // Signals and design instance
  // ----------------------------------------
  typedef struct {
    logic        doWr;
    logic [3:0]  idx;
    logic [15:0] wrVal;
    logic [15:0] expVal;
  } sea_row_t;

  logic        clk_sys = 1'b0;
  logic        sys_rst;
  logic [15:0] operCondIn;
  logic [15:0] quesCondIn;
  logic        cmdRdEn;
  logic        cmdWrEn;
  logic [3:0]  cmdIdx;
  logic [15:0] cmdWrData;
  logic        statusPreset;
  logic [15:0] rdData;
  logic        rdValid;
  logic        operSummary;
  logic        quesSummary;
  logic [7:0]  statusByteBits;
  logic [15:0] acc;
  int          num_errors = 0;
  int          checks = 0;

  sea_row_t rows [9] = '{
    '{1'b1, SEA_IDX_OPER_ENAB, 16'hFFFF, 16'h7FFF},
    '{1'b1, SEA_IDX_OPER_FALL, 16'h1234, 16'h1234},
    '{1'b1, SEA_IDX_OPER_RISE, 16'hA5A5, 16'h25A5},
    '{1'b1, SEA_IDX_QUES_ENAB, 16'h8001, 16'h0001},
    '{1'b1, SEA_IDX_QUES_FALL, 16'h7FFF, 16'h7FFF},
    '{1'b1, SEA_IDX_QUES_RISE, 16'h00F0, 16'h00F0},
    '{1'b1, SEA_IDX_OPER_COND, 16'h7FFF, 16'h0000},
    '{1'b1, SEA_IDX_QUES_EVENT, 16'hFFFF, 16'h0000},
    '{1'b0, 4'hF, 16'h0000, 16'h0000}
  };

  always #5 clk_sys = ~clk_sys;

  status_event_aggregator status_event_aggregator_inst (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .operCondIn     (operCondIn),
    .quesCondIn     (quesCondIn),
    .cmdRdEn        (cmdRdEn),
    .cmdWrEn        (cmdWrEn),
    .cmdIdx         (cmdIdx),
    .cmdWrData      (cmdWrData),
    .statusPreset   (statusPreset),
    .rdData         (rdData),
    .rdValid        (rdValid),
    .operSummary    (operSummary),
    .quesSummary    (quesSummary),
    .statusByteBits (statusByteBits)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run();
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [15:0] data);
    @(posedge clk_sys);
    cmdWrEn   <= 1'b1;
    cmdIdx    <= idx;
    cmdWrData <= data;
    @(posedge clk_sys);
    cmdWrEn <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
    @(posedge clk_sys);
    cmdRdEn <= 1'b1;
    cmdIdx  <= idx;
    @(posedge clk_sys);
    cmdRdEn <= 1'b0;
    #1;
    chk({15'h0000, rdValid}, 16'h0001, "read valid");
    chk(rdData, exp, "read data");
  endtask

  // Condition change, then wait past sync and edge latch
  task automatic setCond(input logic [3:0] b, input logic [15:0] v);
    @(posedge clk_sys);
    if (b == 4'h0)
      operCondIn <= v;
    else
      quesCondIn <= v;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  // One group: rise, fall, mask and summary
  task automatic grp(input logic [3:0] b, input logic [15:0] sb);
    wr(b + 4'h4, 16'h0001);
    wr(b + 4'h3, 16'h0002);
    wr(b + 4'h2, 16'h0003);
    setCond(b, 16'h0003);
    chk({8'h00, statusByteBits}, sb, "summary");
    chk({14'h0000, operSummary, quesSummary}, {14'h0000, sb[7], sb[3]}, "summary pins");
    rd(b, 16'h0001);
    rd(b, 16'h0000);
    rd(b + 4'h1, 16'h0003);
    rd(b + 4'h1, 16'h0003);
    setCond(b, 16'h0001);
    chk({8'h00, statusByteBits}, sb, "summary fall");
    wr(b + 4'h2, 16'h0001);
    chk({8'h00, statusByteBits}, 16'h0000, "masked summary");
    rd(b, 16'h0002);
  endtask

  // Event arriving during back-to-back clearing reads
  task automatic clash(input logic [3:0] b);
    setCond(b, 16'h0000);
    @(posedge clk_sys);
    cmdRdEn <= 1'b1;
    cmdIdx  <= b;
    if (b == 4'h0)
      operCondIn <= 16'h0001;
    else
      quesCondIn <= 16'h0001;
    acc = 16'h0000;
    for (int k = 0; k < 12; k++)
    begin
      @(posedge clk_sys);
      if (k == 9)
        cmdRdEn <= 1'b0;
      #1;
      if (rdValid === 1'b1)
        acc = acc | rdData;
    end
    chk(acc, 16'h0001, "event lost");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    sys_rst      = 1'b1;
    operCondIn   = 16'h0000;
    quesCondIn   = 16'h0000;
    cmdRdEn      = 1'b0;
    cmdWrEn      = 1'b0;
    cmdIdx       = 4'h0;
    cmdWrData    = 16'h0000;
    statusPreset = 1'b0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++)
      rd(4'(i), 16'h0000);
    foreach (rows[i])
    begin
      if (rows[i].doWr)
        wr(rows[i].idx, rows[i].wrVal);
      rd(rows[i].idx, rows[i].expVal);
    end
    grp(SEA_IDX_OPER_EVENT, 16'h0080);
    grp(SEA_IDX_QUES_EVENT, 16'h0008);
    clash(SEA_IDX_OPER_EVENT);
    clash(SEA_IDX_QUES_EVENT);
    // Preset clears pending summary and masks
    wr(SEA_IDX_OPER_ENAB, 16'h7FFF);
    wr(SEA_IDX_OPER_RISE, 16'h7FFF);
    setCond(4'h0, 16'hFFFF);
    chk({15'h0000, operSummary}, 16'h0001, "summary before preset");
    @(posedge clk_sys);
    statusPreset <= 1'b1;
    @(posedge clk_sys);
    statusPreset <= 1'b0;
    #1;
    chk({8'h00, statusByteBits}, 16'h0000, "preset summary");
    rd(SEA_IDX_OPER_ENAB, 16'h0000);
    rd(SEA_IDX_QUES_ENAB, 16'h0000);
    rd(SEA_IDX_OPER_EVENT, 16'h0000);
    complete_run();
  end

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
